// [hdl/pin_select_pkg.sv]
// package: register map, field positions, reset values and mode codes for the pin select block
package pin_select_pkg;

  // ----------------------------------------------------------------
  // register byte addresses (apb, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORTF_MODE   = 8'h00; // port_f_pin_mode_control
  localparam logic [7:0] ADDR_SER_PIN_DATA = 8'h04; // serial_port_pin_data
  localparam logic [7:0] ADDR_SER_PIN_MODE = 8'h08; // serial_pin_mode_control
  localparam logic [7:0] ADDR_SER0_CTRL    = 8'h0C; // serial0_control
  localparam logic [7:0] ADDR_FIFO_CTRL    = 8'h10; // fifo_serial_control
  localparam logic [7:0] ADDR_PIN_STATUS   = 8'h14; // live pin function status

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PF1_MODE_LO_POS   = 2;  // portf_pin1_mode_lo
  localparam int PF1_MODE_HI_POS   = 3;  // portf_pin1_mode_hi
  localparam int SER_PIN5_POS      = 5;  // serial_pin5_value, read only
  localparam int SER_PIN4_POS      = 4;  // serial_pin4_value
  localparam int SER_PIN3_POS      = 3;  // serial_pin3_value
  localparam int RX_EN_POS         = 4;  // receive_enable_bit
  localparam int TX_EN_POS         = 5;  // transmit_enable_bit
  localparam int PORTF_MODE_W      = 16; // port f mode register width
  localparam int SER_PIN_MODE_W    = 16; // serial pin mode register width

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PORTF_MODE_RST   = 16'h0000; // trace function on pin 1
  localparam logic [15:0] SER_PIN_MODE_RST = 16'h0A80; // serial pin mode defaults
  localparam logic [7:0]  SER_CTRL_RST     = 8'h00;    // both enables clear
  localparam logic [2:0]  SER_DATA_RST     = 3'h0;     // data bits 5..3 clear

  // ----------------------------------------------------------------
  // port f pin 1 mode codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PF1_TRACE     = 2'h0, // trace data, two way
    PF1_RESERVED  = 2'h1, // reserved, treated as input
    PF1_IN_PULLUP = 2'h2, // port input, pull-up on
    PF1_IN_NOPULL = 2'h3  // port input, pull-up off
  } pf1_mode_t;

endpackage

// [hdl/portf_pin1_ctrl.sv]
// decodes the port f pin 1 mode field into drive and pull-up controls
`timescale 1ns/1ps
module portf_pin1_ctrl (
  input  wire logic [1:0] mode,        // portf_pin1 mode field
  input  wire logic       trace_out,   // trace data to drive
  input  wire logic       trace_oe,    // trace logic wants to drive
  output logic            pin_out,     // pin output value
  output logic            pin_oe,      // pin output enable, high drives
  output logic            pullup_en,   // pull-up switched on
  output logic            trace_sel    // trace function selected
);

  // ----------------------------------------------------------------
  // decode: only the trace function may drive; port mode is input only
  // ----------------------------------------------------------------
  always_comb begin
    pin_out   = 1'b0;
    pin_oe    = 1'b0;
    pullup_en = 1'b0;
    trace_sel = 1'b0;
    case (mode)
      pin_select_pkg::PF1_TRACE: begin        // two way trace data
        trace_sel = 1'b1;
        pin_out   = trace_out;
        pin_oe    = trace_oe;
      end
      pin_select_pkg::PF1_IN_PULLUP: begin    // input with pull-up
        pullup_en = 1'b1;
      end
      pin_select_pkg::PF1_IN_NOPULL: begin    // input without pull-up
        pullup_en = 1'b0;
      end
      default: begin                          // reserved code: safe input
        pullup_en = 1'b0;
      end
    endcase
  end

endmodule // portf_pin1_ctrl

// [hdl/serial_pin_route.sv]
// routes one serial tx/rx pin pair between peripheral function and port mode
`timescale 1ns/1ps
module serial_pin_route (
  input  wire logic       tx_en,        // transmit enable of the channel
  input  wire logic       rx_en,        // receive enable of the channel
  input  wire logic [1:0] tx_port_mode, // stored port mode of the tx pin
  input  wire logic [1:0] rx_port_mode, // stored port mode of the rx pin
  output logic            tx_is_func,   // tx pin carries serial transmit data
  output logic            rx_is_func,   // rx pin carries serial receive data
  output logic [1:0]      tx_mode_eff,  // effective tx pin mode
  output logic [1:0]      rx_mode_eff   // effective rx pin mode
);

  // ----------------------------------------------------------------
  // override: an enable wins over the stored mode, stored mode untouched
  // ----------------------------------------------------------------
  always_comb begin
    tx_is_func  = tx_en;
    rx_is_func  = rx_en;
    tx_mode_eff = tx_en ? 2'h0 : tx_port_mode;
    rx_mode_eff = rx_en ? 2'h0 : rx_port_mode;
  end

endmodule // serial_pin_route

// [hdl/serial_portf_pin_select.sv]
// top: apb registers and pin function selection for serial pins and port f pin 1
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module serial_portf_pin_select (
  input  wire logic        pclk,               // apb clock
  input  wire logic        presetn,            // async reset, active low
  input  wire logic        psel,               // apb select
  input  wire logic        penable,            // apb access phase
  input  wire logic        pwrite,             // apb direction
  input  wire logic [7:0]  paddr,              // apb byte address
  input  wire logic [31:0] pwdata,             // apb write data
  output logic      [31:0] prdata,             // apb read data
  output logic             pready,             // apb ready
  output logic             pslverr,            // apb error, unmapped
  input  wire logic        serial_pin5_in,     // level seen on serial pin 5
  input  wire logic        ser0_txd,           // serial0 transmit data
  input  wire logic        fifo_serial_txd,    // fifo channel transmit data
  input  wire logic        trace_data_out,     // trace data to the pin
  input  wire logic        trace_data_oe,      // trace wants to drive
  input  wire logic        portf_pin1_in,      // level on portf_pin1
  output logic             ser0_tx_out,        // serial0 tx pin value
  output logic             ser0_tx_oe,         // serial0 tx pin enable
  output logic             ser0_rx_sel,        // serial0 rx pin routed in
  output logic             fifo_serial_tx_line,// fifo tx pin value
  output logic             fifo_serial_tx_oe,  // fifo tx pin enable
  output logic             fifo_serial_rx_sel, // fifo rx pin routed in
  output logic             portf_pin1_out,     // pin 1 output value
  output logic             portf_pin1_oe,      // pin 1 output enable
  output logic             portf_pin1_pullup,  // pin 1 pull-up on
  output logic             trace_data_bit1_in  // pin 1 level to trace logic
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] portf_mode_r;     // port_f_pin_mode_control
  logic [15:0] ser_pin_mode_r;   // serial_pin_mode_control
  logic [7:0]  ser0_ctrl_r;      // serial0_control
  logic [7:0]  fifo_ctrl_r;      // fifo_serial_control
  logic [1:0]  ser_data_r;       // serial pin 4 and 3 values
  logic        pin5_r;           // sampled serial pin 5

  logic        wr_en;            // write in access phase
  logic        rd_en;            // read in access phase
  logic        hit;              // address mapped
  logic [31:0] rd_nxt;           // read mux

  // combinational pin decode
  logic        s0_tx_f, s0_rx_f, f_tx_f, f_rx_f;
  logic [1:0]  s0_tx_m, f_tx_m;
  logic        p1_out, p1_oe, p1_pull, p1_trace;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always_comb begin
    case (paddr)
      pin_select_pkg::ADDR_PORTF_MODE,
      pin_select_pkg::ADDR_SER_PIN_DATA,
      pin_select_pkg::ADDR_SER_PIN_MODE,
      pin_select_pkg::ADDR_SER0_CTRL,
      pin_select_pkg::ADDR_FIFO_CTRL,
      pin_select_pkg::ADDR_PIN_STATUS: hit = 1'b1;
      default:                         hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // port f mode register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      portf_mode_r <= pin_select_pkg::PORTF_MODE_RST;
    end else if (wr_en && paddr == pin_select_pkg::ADDR_PORTF_MODE) begin
      portf_mode_r <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // serial pin mode register, never touched by the enables
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_pin_mode_r <= pin_select_pkg::SER_PIN_MODE_RST;
    end else if (wr_en && paddr == pin_select_pkg::ADDR_SER_PIN_MODE) begin
      ser_pin_mode_r <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // serial channel control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser0_ctrl_r <= pin_select_pkg::SER_CTRL_RST;
      fifo_ctrl_r <= pin_select_pkg::SER_CTRL_RST;
    end else if (wr_en) begin
      if (paddr == pin_select_pkg::ADDR_SER0_CTRL) begin
        ser0_ctrl_r <= pwdata[7:0];
      end
      if (paddr == pin_select_pkg::ADDR_FIFO_CTRL) begin
        fifo_ctrl_r <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // serial port data: bits 4,3 writable, bit 5 follows the pin
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_data_r <= pin_select_pkg::SER_DATA_RST[1:0];
      pin5_r     <= 1'b0;
    end else begin
      pin5_r <= serial_pin5_in;
      if (wr_en && paddr == pin_select_pkg::ADDR_SER_PIN_DATA) begin
        ser_data_r <= pwdata[pin_select_pkg::SER_PIN4_POS:pin_select_pkg::SER_PIN3_POS];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------
  serial_pin_route u_ser0 (
    .tx_en        (ser0_ctrl_r[pin_select_pkg::TX_EN_POS]),
    .rx_en        (ser0_ctrl_r[pin_select_pkg::RX_EN_POS]),
    .tx_port_mode (ser_pin_mode_r[1:0]),
    .rx_port_mode (ser_pin_mode_r[1:0]),
    .tx_is_func   (s0_tx_f),
    .rx_is_func   (s0_rx_f),
    .tx_mode_eff  (s0_tx_m),
    .rx_mode_eff  ()
  );

  serial_pin_route u_fifo (
    .tx_en        (fifo_ctrl_r[pin_select_pkg::TX_EN_POS]),
    .rx_en        (fifo_ctrl_r[pin_select_pkg::RX_EN_POS]),
    .tx_port_mode (ser_pin_mode_r[5:4]),
    .rx_port_mode (ser_pin_mode_r[5:4]),
    .tx_is_func   (f_tx_f),
    .rx_is_func   (f_rx_f),
    .tx_mode_eff  (f_tx_m),
    .rx_mode_eff  ()
  );

  portf_pin1_ctrl u_pf1 (
    .mode      (portf_mode_r[pin_select_pkg::PF1_MODE_HI_POS:pin_select_pkg::PF1_MODE_LO_POS]),
    .trace_out (trace_data_out),
    .trace_oe  (trace_data_oe),
    .pin_out   (p1_out),
    .pin_oe    (p1_oe),
    .pullup_en (p1_pull),
    .trace_sel (p1_trace)
  );

  // ----------------------------------------------------------------
  // registered pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser0_tx_out         <= 1'b0;
      ser0_tx_oe          <= 1'b0;
      ser0_rx_sel         <= 1'b0;
      fifo_serial_tx_line <= 1'b0;
      fifo_serial_tx_oe   <= 1'b0;
      fifo_serial_rx_sel  <= 1'b0;
      portf_pin1_out      <= 1'b0;
      portf_pin1_oe       <= 1'b0;
      portf_pin1_pullup   <= 1'b0;
      trace_data_bit1_in  <= 1'b0;
    end else begin
      ser0_tx_out         <= s0_tx_f & ser0_txd;
      ser0_tx_oe          <= s0_tx_f;
      ser0_rx_sel         <= s0_rx_f;
      fifo_serial_tx_line <= f_tx_f & fifo_serial_txd;
      fifo_serial_tx_oe   <= f_tx_f;
      fifo_serial_rx_sel  <= f_rx_f;
      portf_pin1_out      <= p1_out;
      portf_pin1_oe       <= p1_oe;
      portf_pin1_pullup   <= p1_pull;
      trace_data_bit1_in  <= p1_trace & portf_pin1_in;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      pin_select_pkg::ADDR_PORTF_MODE:   rd_nxt[15:0] = portf_mode_r;
      pin_select_pkg::ADDR_SER_PIN_DATA: rd_nxt[5:3]  = {pin5_r, ser_data_r};
      pin_select_pkg::ADDR_SER_PIN_MODE: rd_nxt[15:0] = ser_pin_mode_r;
      pin_select_pkg::ADDR_SER0_CTRL:    rd_nxt[7:0]  = ser0_ctrl_r;
      pin_select_pkg::ADDR_FIFO_CTRL:    rd_nxt[7:0]  = fifo_ctrl_r;
      pin_select_pkg::ADDR_PIN_STATUS:   rd_nxt[7:0]  = {s0_tx_m, f_tx_m, s0_tx_f,
                                                         s0_rx_f, f_tx_f, f_rx_f};
      default:                           rd_nxt = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // apb answer: ready held high, no wait states in the access phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_nxt : prdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_ser0_tx;
    @(posedge pclk) disable iff (!presetn)
      ser0_ctrl_r[pin_select_pkg::TX_EN_POS] |=> ser0_tx_oe;
  endproperty
  a_ser0_tx: assert property (p_ser0_tx) else $error("serial0 tx not routed");

  property p_ser0_rx;
    @(posedge pclk) disable iff (!presetn)
      ser0_ctrl_r[pin_select_pkg::RX_EN_POS] |=> ser0_rx_sel;
  endproperty
  a_ser0_rx: assert property (p_ser0_rx) else $error("serial0 rx not routed");

  property p_fifo_tx;
    @(posedge pclk) disable iff (!presetn)
      fifo_ctrl_r[pin_select_pkg::TX_EN_POS] |=> fifo_serial_tx_oe;
  endproperty
  a_fifo_tx: assert property (p_fifo_tx) else $error("fifo tx not routed");

  property p_fifo_rx;
    @(posedge pclk) disable iff (!presetn)
      fifo_ctrl_r[pin_select_pkg::RX_EN_POS] |=> fifo_serial_rx_sel;
  endproperty
  a_fifo_rx: assert property (p_fifo_rx) else $error("fifo rx not routed");

  property p_pf1_pull;
    @(posedge pclk) disable iff (!presetn)
      (portf_mode_r[3:2] == 2'h2) |=> portf_pin1_pullup;
  endproperty
  a_pf1_pull: assert property (p_pf1_pull) else $error("pull-up not on");

  property p_pf1_in;
    @(posedge pclk) disable iff (!presetn)
      (portf_mode_r[3:2] != 2'h0) |=> !portf_pin1_oe;
  endproperty
  a_pf1_in: assert property (p_pf1_in) else $error("port pin driven");

  property p_pin5_ro;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == pin_select_pkg::ADDR_SER_PIN_DATA)
        |=> pin5_r == $past(serial_pin5_in);
  endproperty
  a_pin5_ro: assert property (p_pin5_ro) else $error("bit 5 written");

  property p_restore;
    @(posedge pclk) disable iff (!presetn)
      $fell(ser0_ctrl_r[pin_select_pkg::TX_EN_POS])
        |-> (s0_tx_m == ser_pin_mode_r[1:0]) ##1 !ser0_tx_oe;
  endproperty
  a_restore: assert property (p_restore) else $error("override not released");

  // fifo tx pin falls back to its stored mode once the enable drops
  property p_fifo_restore;
    @(posedge pclk) disable iff (!presetn)
      $fell(fifo_ctrl_r[pin_select_pkg::TX_EN_POS])
        |-> (f_tx_m == ser_pin_mode_r[5:4]) ##1 !fifo_serial_tx_oe;
  endproperty
  a_fifo_restore: assert property (p_fifo_restore) else $error("fifo override stuck");

  // serial0 tx pin carries the channel data while enabled
  property p_ser0_txdata;
    @(posedge pclk) disable iff (!presetn)
      ser0_ctrl_r[pin_select_pkg::TX_EN_POS] |=> ser0_tx_out == $past(ser0_txd);
  endproperty
  a_ser0_txdata: assert property (p_ser0_txdata) else $error("serial0 tx data wrong");

  // trace mode hands the drive enable to the trace logic
  property p_pf1_trace;
    @(posedge pclk) disable iff (!presetn)
      (portf_mode_r[3:2] == 2'h0) |=> portf_pin1_oe == $past(trace_data_oe);
  endproperty
  a_pf1_trace: assert property (p_pf1_trace) else $error("trace drive lost");

  // pull-up only in the pull-up input code
  property p_pf1_nopull;
    @(posedge pclk) disable iff (!presetn)
      (portf_mode_r[3:2] != 2'h2) |=> !portf_pin1_pullup;
  endproperty
  a_pf1_nopull: assert property (p_pf1_nopull) else $error("pull-up wrongly on");

endmodule // serial_portf_pin_select

// [tb/pin_world.sv]
// partner model: board wiring of port f pin 1 and serial pin 5
`timescale 1ns/1ps
module pin_world (
  input  wire logic pclk,      // bus clock, paces the float pattern
  input  wire logic pin_out,   // device drive value
  input  wire logic pin_oe,    // device drives the pin
  input  wire logic pullup_en, // device pull-up switched on
  input  wire logic ext_en,    // board drives the pin
  input  wire logic ext_level, // board drive value
  input  wire logic pin5_lvl,  // board level on serial pin 5
  output logic      pin_level, // resolved pin 1 level
  output logic      pin5_in    // serial pin 5 as the device sees it
);
  logic float_r = 1'b0; // undriven pin wanders every cycle
  // ---------------------------------------------------------------
  // pin resolution
  // ---------------------------------------------------------------
  always_ff @(posedge pclk) begin
    float_r <= ~float_r;
  end
  // device first, then board, then pull-up, else a moving value
  always_comb begin
    if (pin_oe) begin
      pin_level = pin_out;
    end else if (ext_en) begin
      pin_level = ext_level;
    end else if (pullup_en) begin
      pin_level = 1'b1;
    end else begin
      pin_level = float_r;
    end
  end
  assign pin5_in = pin5_lvl; // plain input pin
endmodule // pin_world

// [tb/tb_top.sv]
// self-checking bench for the serial and port f pin select block
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, rerr;
  logic        ser0_txd = 1'b0, fifo_txd = 1'b0, tr_out = 1'b0, tr_oe = 1'b0;
  logic        ext_en = 1'b0, ext_level = 1'b0, pin5_lvl = 1'b0;
  logic        tx_out, tx_oe, rx_sel, f_tx, f_oe, f_rx, p_out, p_oe, p_pu, tr_in;
  logic        p_in, pin5_in;
  logic [3:0]  sel;                 // function selected per case
  logic [1:0]  txv;                 // tx line values
  int          mismatches = 0, checked = 0, cycles = 0;
  assign sel = {f_rx, f_oe, rx_sel, tx_oe};
  assign txv = {f_tx, tx_out};
  always #20 pclk = ~pclk;          // 25 MHz
  serial_portf_pin_select DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_pin5_in(pin5_in),
    .ser0_txd(ser0_txd), .fifo_serial_txd(fifo_txd), .trace_data_out(tr_out),
    .trace_data_oe(tr_oe), .portf_pin1_in(p_in), .ser0_tx_out(tx_out),
    .ser0_tx_oe(tx_oe), .ser0_rx_sel(rx_sel), .fifo_serial_tx_line(f_tx),
    .fifo_serial_tx_oe(f_oe), .fifo_serial_rx_sel(f_rx), .portf_pin1_out(p_out),
    .portf_pin1_oe(p_oe), .portf_pin1_pullup(p_pu), .trace_data_bit1_in(tr_in));
  pin_world board (.pclk(pclk), .pin_out(p_out), .pin_oe(p_oe), .pullup_en(p_pu),
    .ext_en(ext_en), .ext_level(ext_level), .pin5_lvl(pin5_lvl),
    .pin_level(p_in), .pin5_in(pin5_in));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic checkb(input string what, input logic seen, input logic exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // let register and pin stages land
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(pin_select_pkg::ADDR_PORTF_MODE);
    check("portf mode rst", rdata, 32'h0);
    checkb("mapped rd err", rerr, 1'b0);
    rd(pin_select_pkg::ADDR_SER_PIN_DATA);
    check("pin data rst", rdata, 32'h0);
    rd(pin_select_pkg::ADDR_SER_PIN_MODE);
    check("pin mode rst", rdata, {16'h0, pin_select_pkg::SER_PIN_MODE_RST});
    rd(pin_select_pkg::ADDR_SER0_CTRL);
    check("ser0 ctrl rst", rdata, 32'h0);
    rd(pin_select_pkg::ADDR_FIFO_CTRL);
    check("fifo ctrl rst", rdata, 32'h0);
  endtask
  // every pin 1 mode code, driving from inside then from the board
  task automatic t_portf;
    logic [1:0] modes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    logic       pu [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(pin_select_pkg::ADDR_PORTF_MODE, {28'h0, modes[i], 2'h0});
      rd(pin_select_pkg::ADDR_PORTF_MODE);
      check("portf mode", rdata, {28'h0, modes[i], 2'h0});
      @(posedge pclk);
      tr_oe <= 1'b1;
      tr_out <= 1'b1;
      settle;
      checkb("pin1 oe", p_oe, modes[i] == 2'h0);
      checkb("pin1 pullup", p_pu, pu[i]);
      checkb("pin1 out", p_out, modes[i] == 2'h0);
      @(posedge pclk);
      tr_oe <= 1'b0;
      ext_en <= 1'b1;
      ext_level <= 1'b1;
      settle;
      checkb("pin1 oe idle", p_oe, 1'b0);
      checkb("pin1 to trace", tr_in, modes[i] == 2'h0);
      @(posedge pclk);
      ext_en <= 1'b0;
    end
  endtask
  // each enable overrides a changed stored mode, clearing restores it
  task automatic t_serial;
    logic [7:0] ca [4] = '{pin_select_pkg::ADDR_SER0_CTRL, pin_select_pkg::ADDR_SER0_CTRL,
                           pin_select_pkg::ADDR_FIFO_CTRL, pin_select_pkg::ADDR_FIFO_CTRL};
    int         bp [4] = '{pin_select_pkg::TX_EN_POS, pin_select_pkg::RX_EN_POS,
                           pin_select_pkg::TX_EN_POS, pin_select_pkg::RX_EN_POS};
    int         sb [4] = '{3, 2, 1, 0};
    for (int i = 0; i < 4; i++) begin
      wr(ca[i], 32'h1 << bp[i]);
      wr(pin_select_pkg::ADDR_SER_PIN_MODE, 32'h0000_0555);
      settle;
      rd(pin_select_pkg::ADDR_PIN_STATUS);
      checkb("status on", rdata[sb[i]], 1'b1);
      check("eff mode on", {28'h0, rdata[7:4]},
            {28'h0, (i == 0) ? 2'h0 : 2'h1, (i == 2) ? 2'h0 : 2'h1});
      checkb("function on", sel[i], 1'b1);
      for (int v = 0; v < 2; v++) begin
        @(posedge pclk);
        ser0_txd <= v[0];
        fifo_txd <= v[0];
        settle;
        if (i[0] == 1'b0) checkb("tx data", txv[i/2], v[0]);
      end
      wr(ca[i], 32'h0);
      settle;
      rd(pin_select_pkg::ADDR_PIN_STATUS);
      checkb("status off", rdata[sb[i]], 1'b0);
      checkb("function off", sel[i], 1'b0);
      check("eff mode off", {28'h0, rdata[7:4]}, 32'h0000_0005);
      rd(pin_select_pkg::ADDR_SER_PIN_MODE);
      check("stored mode", rdata, 32'h0000_0555);
      wr(pin_select_pkg::ADDR_SER_PIN_MODE, {16'h0, pin_select_pkg::SER_PIN_MODE_RST});
    end
  endtask
  // bit 5 follows the pin, bits 4 and 3 hold what was written
  task automatic t_data;
    wr(pin_select_pkg::ADDR_SER_PIN_DATA, 32'h0000_00FF);
    rd(pin_select_pkg::ADDR_SER_PIN_DATA);
    check("pin data wr", rdata, 32'h0000_0018);
    @(posedge pclk);
    pin5_lvl <= 1'b1;
    settle;
    rd(pin_select_pkg::ADDR_SER_PIN_DATA);
    check("pin data pin5", rdata, 32'h0000_0038);
    wr(pin_select_pkg::ADDR_SER_PIN_DATA, 32'h0);
    rd(pin_select_pkg::ADDR_SER_PIN_DATA);
    check("pin data clr", rdata, 32'h0000_0020);
  endtask
  // unmapped place: refused with an error, reads zero
  task automatic t_unmapped;
    wr(8'h18, 32'hFFFF_FFFF);
    checkb("unmapped wr err", rerr, 1'b1);
    rd(8'h18);
    checkb("unmapped rd err", rerr, 1'b1);
    check("unmapped rd", rdata, 32'h0);
  endtask
  // ---------------------------------------------------------------
  // sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude;
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_portf;
    t_serial;
    t_data;
    t_unmapped;
    conclude;
  end
endmodule // tb_top
